// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import txdaf_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0, slow = 0;
  logic tx_running_i = 0, rx_busy_i = 0, loopback_i = 0, dest_valid_i = 0;
  logic [7:0] addr_i = '0;
  logic [31:0] wr_data_i = '0, seg_addr_o, rd_data_o;
  logic [47:0] dest_addr_i = '0;
  logic [14:0] rep = '0, tx_report_i, seg_len_o;
  logic tx_done_i, seg_req_o, seg_is_pte_o, seg_pte_kind_o, frame_end_o;
  logic crc_append_o, pad_o, chain_o, desc_done_o, rx_disengage_o;
  logic tx_interrupt_flag_o, filter_valid_o, filter_accept_o;
  logic [8:0] seg_offset_o;
  logic [1:0] content_type_o;
  logic [15:0] frame_len_o;
  int miscompares = 0, n_compared = 0, nseg = 0, nchain = 0;
  localparam logic [47:0] A = 48'h7634126509A8, B = 48'h7634126509AC;
  localparam logic [47:0] C = 48'h1503DE87BC09, M = 48'h1503DE87BC0B;
  txdaf_top txdaf_top_i (.*);
  txdaf_chan txdaf_chan_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .frame_end_i(frame_end_o), .report_i(rep), .slow_i(slow),
    .tx_done_o(tx_done_i), .tx_report_o(tx_report_i));
  // Clock and pulse tallies
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    nseg += seg_req_o;
    nchain += chain_o;
  end
  task summarize;
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 chk(n, e, rd_data_o);
  endtask
  // Bounded wait for the end of a descriptor
  task sub(input logic [31:0] w1, w2, w3);
    int i;
    wr(REG_DESC1, w1);
    wr(REG_DESC2, w2);
    wr(REG_DESC3, w3);
    wr(REG_DESC0, 32'h80000000);
    for (i = 0; i < 300 && desc_done_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 300) chk("done", 1, 0);
  endtask
  task flt(input logic [47:0] d, input logic e);
    @(posedge clk_i);
    dest_addr_i <= d;
    dest_valid_i <= 1'b1;
    @(posedge clk_i);
    dest_addr_i <= ~d;
    dest_valid_i <= 1'b0;
    #1 chk("filter", {1'b1, e}, {filter_valid_o, filter_accept_o});
  endtask
  task fill(input logic [31:0] a, b);
    for (int n = 0; n < 32; n += 2) begin
      wr(8'h80 + 8'(4 * n), a);
      wr(8'h84 + 8'(4 * n), b);
    end
  endtask
  // Own model of the address hash, low address bit first
  function automatic logic [8:0] hidx(input logic [47:0] a);
    logic [32:0] c;
    logic [8:0] r;
    c = 33'h1FFFFFFFE;
    for (int j = 0; j < 48; j++)
      c = {c[31:0], 1'b0} ^ ((c[32] ^ a[j]) ? 33'h009823B6E : 33'h0);
    // Stage 24 is shifted in first, so it ends up as the top index bit
    for (int k = 0; k < 9; k++)
      r[8-k] = c[24+k];
    return r;
  endfunction
  // Watchdog well past the expected run length
  initial begin
    #300000;
    miscompares++;
    summarize;
  end
  // Main sequence
  initial begin
    logic [8:0] h;
    int c;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc("stat", REG_STAT, 0);
    rdc("unmap", 8'h1C, 0);
    flt(48'h0, 1'b1);
    flt(A, 1'b0);
    rep <= 15'h0118;
    sub(32'h0E000000, 32'h00640000, 32'h00001000);
    chk("len", 100, frame_len_o);
    chk("crc", 0, {crc_append_o, pad_o});
    rdc("desc0", REG_DESC0, 32'h00008100);
    // Underrun hides carrier and heartbeat flags but keeps the tally
    rep <= 15'h0C92;
    sub(32'h07000000, 32'h00640000, 32'h00007000);
    chk("crc2", 2, {crc_append_o, pad_o});
    rdc("uf", REG_DESC0, 32'h00008012);
    rdc("ti", REG_STAT, 32'h1);
    wr(REG_STAT, 32'h1);
    rep <= 15'h0000;
    slow <= 1'b1;
    sub(32'h7E000000, 32'h001401FF, 32'h00002000);
    chk("virt", {17'h0, 1'b1, 1'b1, 9'h1FF, 2'h3, 1'b1, 1'b1},
      {17'h0, seg_is_pte_o, seg_pte_kind_o, seg_offset_o, content_type_o,
      pad_o, crc_append_o});
    chk("addr", 32'h2000, seg_addr_o);
    chk("slen", 20, seg_len_o);
    c = nseg;
    sub(32'h0C000000, 32'h001E0000, 32'h00003000);
    sub(32'h00000000, 32'h00000000, 32'h00004000);
    sub(32'h02000000, 32'h00320000, 32'h00005000);
    chk("len", 80, frame_len_o);
    chk("crc", 0, {crc_append_o, pad_o});
    chk("nseg", 2, nseg - c);
    c = nchain;
    sub(32'h80000000, 32'h0, 32'h00006000);
    // The tally takes the pulse at the edge after it
    @(posedge clk_i);
    #1;
    chk("chain", {31'h0, 1'b1} + 32'(c), 32'(nchain));
    chk("next", 32'h6000, seg_addr_o);
    fill(32'h126509A8, 32'h00007634);
    wr(8'hF8, 32'hDE87BC09);
    wr(8'hFC, 32'h00001503);
    fork
      sub(32'h21000000, 32'h00800000, 32'h00000100);
      begin
        repeat (14) @(posedge clk_i);
        rx_busy_i <= 1'b1;
        tx_running_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("held", 0, rx_disengage_o);
        rx_busy_i <= 1'b0;
      end
    join
    rdc("stat", REG_STAT, 32'h1);
    wr(REG_STAT, 32'h1);
    rdc("stat", REG_STAT, 0);
    flt(A, 1'b1);
    flt(C, 1'b1);
    flt(B, 1'b0);
    sub(32'h24000000, 32'h00800000, 32'h00000100);
    flt(A, 1'b0);
    flt(B, 1'b1);
    sub(32'h20000000, 32'h00640000, 32'h00000100);
    rdc("setup", REG_DESC0, 32'h0000A000);
    flt(A, 1'b0);
    fill(32'h0, 32'h0);
    h = hidx(C);
    wr(8'h80 + {2'h0, h[8:5], 2'h0}, 32'h1 << h[4:0]);
    wr(8'hE8, 32'h126509A8);
    wr(8'hEC, 32'h00007634);
    sub(32'h22000000, 32'h00800000, 32'h00000100);
    flt(C, 1'b1);
    flt(M, hidx(M) == h);
    flt(A, 1'b1);
    flt(B, 1'b0);
    // All-multicast passes any group address, promiscuous passes all
    wr(REG_CTRL, 32'h2);
    flt(M, 1'b1);
    flt(B, 1'b0);
    wr(REG_CTRL, 32'h1);
    rdc("ctrl", REG_CTRL, 32'h1);
    flt(B, 1'b1);
    summarize;
  end
endmodule
`default_nettype wire

// ==== txdaf_chan.sv ====
`default_nettype none
module txdaf_chan (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic frame_end_i,
  input wire logic [14:0] report_i,
  input wire logic slow_i,
  output logic tx_done_o,
  output logic [14:0] tx_report_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // One report per frame; report lines churn outside it to expose misuse
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      tx_done_o <= 1'b0;
      tx_report_o <= '0;
    end else begin
      tx_done_o <= (cnt == 1);
      tx_report_o <= (cnt == 1) ? report_i : ~tx_report_o;
      if (frame_end_i) cnt <= slow_i ? 12 : 3;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ==== txdaf_checker.sv ====
`default_nettype none
module txdaf_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [txdaf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [txdaf_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic tx_running_i,
  input wire logic rx_busy_i,
  input wire logic dest_valid_i,
  input wire logic seg_req_o,
  input wire logic seg_is_pte_o,
  input wire logic [8:0] seg_offset_o,
  input wire logic [14:0] seg_len_o,
  input wire logic [1:0] content_type_o,
  input wire logic frame_end_o,
  input wire logic [15:0] frame_len_o,
  input wire logic crc_append_o,
  input wire logic pad_o,
  input wire logic desc_done_o,
  input wire logic rx_disengage_o,
  input wire logic tx_interrupt_flag_o,
  input wire logic filter_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import txdaf_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_filter_latency: assert property (
    filter_valid_o == $past(dest_valid_i))
    else $error("filter verdict not one cycle after request");
  a_short_pad: assert property (
    frame_end_o && frame_len_o < MIN_FRAME |-> pad_o && crc_append_o)
    else $error("short frame lacks pad or crc");
  a_long_nopad: assert property (
    frame_end_o && frame_len_o >= MIN_FRAME |-> !pad_o)
    else $error("long frame padded");
  a_seg_nonzero: assert property (
    seg_req_o |-> seg_len_o != 15'h0000)
    else $error("empty segment fetched");
  a_phys_offset: assert property (
    seg_req_o && !seg_is_pte_o |-> seg_offset_o == 9'h000)
    else $error("offset used without virtual mode");
  a_setup_hidden: assert property (
    seg_req_o |-> content_type_o != DT_SETUP && !rx_disengage_o)
    else $error("setup data sent to channel");
  a_disengage_len: assert property (
    rx_disengage_o |=> !rx_disengage_o && desc_done_o)
    else $error("receiver release wrong");
  a_disengage_cause: assert property (
    $rose(rx_disengage_o) |-> $past(tx_running_i && !rx_busy_i))
    else $error("setup ran while not allowed");
  a_flag_sticky: assert property (
    tx_interrupt_flag_o && !(wr_en_i && addr_i == REG_STAT &&
    wr_data_i[ST_TI_BIT]) |=> tx_interrupt_flag_o)
    else $error("interrupt flag lost");
  c_setup: cover property (rx_disengage_o);
  c_pad: cover property (frame_end_o && pad_o);
  c_flag: cover property ($rose(tx_interrupt_flag_o));
endmodule
bind txdaf_top txdaf_checker txdaf_checker_i (.*);
`default_nettype wire

// ==== txdaf_hash.sv ====
`default_nettype none
// Hash index of a destination address: serial CRC, low address bit first
module txdaf_hash (
  input wire logic [47:0] addr_i,
  output logic [8:0] index_o
);
  import txdaf_pkg::*;

  // Bit-serial CRC unrolled over the 48 address bits
  always_comb begin
    logic [31:0] s;
    logic fb;
    s = CRC_INIT;
    fb = 1'b0;
    for (int j = 0; j < 48; j++) begin
      fb = s[31] ^ addr_i[j];
      s = {s[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    // Top nine residue bits, highest stage landing in the low index bit
    for (int m = 0; m < 9; m++) begin
      index_o[8-m] = s[23+m];
    end
  end
endmodule
`default_nettype wire

// ==== txdaf_pkg.sv ====
`default_nettype none
package txdaf_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DESC0 = 8'h04;
  localparam logic [7:0] REG_DESC1 = 8'h08;
  localparam logic [7:0] REG_DESC2 = 8'h0C;
  localparam logic [7:0] REG_DESC3 = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_FLEN = 8'h18;
  localparam int BUF_SEL_BIT = 7;
  // Descriptor word fields
  localparam int OWN_BIT = 31;
  localparam int CA_BIT = 31;
  localparam int VA_BIT = 30;
  localparam int VT_BIT = 29;
  localparam int DT_HI = 29;
  localparam int DT_LO = 28;
  localparam int AC_BIT = 27;
  localparam int FS_BIT = 26;
  localparam int LS_BIT = 25;
  localparam int IC_BIT = 24;
  localparam int HP_BIT = 25;
  localparam int IF_BIT = 26;
  localparam int BS_HI = 30;
  localparam int BS_LO = 16;
  localparam int PO_HI = 8;
  // Status word fields
  localparam int ES_BIT = 15;
  localparam int TO_BIT = 14;
  localparam int SE_BIT = 13;
  localparam int LE_BIT = 12;
  localparam int LO_BIT = 11;
  localparam int NC_BIT = 10;
  localparam int LC_BIT = 9;
  localparam int EC_BIT = 8;
  localparam int HF_BIT = 7;
  localparam int CC_HI = 6;
  localparam int CC_LO = 3;
  localparam int TN_BIT = 2;
  localparam int UF_BIT = 1;
  // Control and status register bits
  localparam int AF_PROM_BIT = 0;
  localparam int AF_MULTI_BIT = 1;
  localparam int ST_TI_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_HASH_BIT = 2;
  localparam int ST_INV_BIT = 3;
  // Data type codes
  localparam logic [1:0] DT_NORMAL = 2'h0;
  localparam logic [1:0] DT_SETUP = 2'h2;
  localparam logic [1:0] DT_DIAG = 2'h3;
  // Frame and filter figures
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [14:0] SETUP_LEN = 15'h0080;
  localparam int BUF_WORDS = 32;
  localparam int PERFECT_ENTRIES = 16;
  localparam int HASH_PHYS_WORD = 26;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_SETUP_WAIT = 3'b010,
    ST_SETUP = 3'b011,
    ST_TX_WAIT = 3'b100
  } txdaf_state_type;
endpackage
`default_nettype wire

// ==== txdaf_top.sv ====
`default_nettype none
module txdaf_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [txdaf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [txdaf_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [txdaf_pkg::DATA_W-1:0] rd_data_o,
  input wire logic tx_running_i,
  input wire logic rx_busy_i,
  input wire logic tx_done_i,
  input wire logic [14:0] tx_report_i,
  input wire logic loopback_i,
  input wire logic dest_valid_i,
  input wire logic [47:0] dest_addr_i,
  output logic seg_req_o,
  output logic [31:0] seg_addr_o,
  output logic seg_is_pte_o,
  output logic seg_pte_kind_o,
  output logic [8:0] seg_offset_o,
  output logic [14:0] seg_len_o,
  output logic [1:0] content_type_o,
  output logic frame_end_o,
  output logic [15:0] frame_len_o,
  output logic crc_append_o,
  output logic pad_o,
  output logic chain_o,
  output logic desc_done_o,
  output logic rx_disengage_o,
  output logic tx_interrupt_flag_o,
  output logic filter_valid_o,
  output logic filter_accept_o
);
  import txdaf_pkg::*;

  typedef struct packed {
    txdaf_state_type st;
    logic [BUF_WORDS-1:0][31:0] sbuf;
    logic [BUF_WORDS-1:0][31:0] ftab;
    logic hash_mode;
    logic inverse;
    logic [1:0] af;
    logic own;
    logic [15:0] stat;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [15:0] flen;
    logic inh;
    logic ti;
    logic [31:0] rdata;
    logic seg_req;
    logic [31:0] seg_addr;
    logic seg_pte;
    logic seg_kind;
    logic [8:0] seg_off;
    logic [14:0] seg_len;
    logic [1:0] ctype;
    logic frame_end;
    logic [15:0] frame_len;
    logic crc_app;
    logic pad;
    logic chain;
    logic done;
    logic disengage;
    logic fvalid;
    logic faccept;
  } txdaf_regs_type;

  txdaf_regs_type q;
  txdaf_regs_type d;

  // Byte count of a descriptor's size word
  function automatic logic [14:0] txdaf_size(input logic [31:0] w);
    txdaf_size = w[BS_HI:BS_LO];
  endfunction

  // Data type code of a descriptor's control word
  function automatic logic [1:0] txdaf_type(input logic [31:0] w);
    txdaf_type = w[DT_HI:DT_LO];
  endfunction

  logic [8:0] hash_idx;
  logic [PERFECT_ENTRIES-1:0] pmatch;
  logic [511:0] hash_bits;

  txdaf_hash u_hash (
    .addr_i(dest_addr_i),
    .index_o(hash_idx)
  );

  // One comparator per stored perfect entry, two longwords each
  for (genvar i = 0; i < PERFECT_ENTRIES; i++) begin : g_pm
    assign pmatch[i] = dest_addr_i ==
      {q.ftab[2*i+1][15:0], q.ftab[2*i]};
  end

  // The first sixteen longwords, bit 0 of word 0 is index 0
  assign hash_bits = q.ftab[15:0];

  always_comb begin
    logic [14:0] bs;
    logic [15:0] nlen;
    logic ninh;
    logic [14:0] rep;
    logic es;
    logic mcast;
    logic acc;
    d = q;
    bs = txdaf_size(q.w2);
    nlen = 16'h0000;
    ninh = 1'b0;
    rep = tx_report_i;
    es = 1'b0;
    mcast = dest_addr_i[0];
    acc = 1'b0;

    // Strobes and pulses last a single cycle
    d.rdata = 32'h00000000;
    d.seg_req = 1'b0;
    d.frame_end = 1'b0;
    d.chain = 1'b0;
    d.done = 1'b0;
    d.fvalid = 1'b0;

    // Read data is produced for the cycle after the read strobe only
    if (rd_en_i) begin
      if (addr_i[BUF_SEL_BIT]) begin
        d.rdata = q.sbuf[addr_i[6:2]];
      end else begin
        unique case (addr_i)
          REG_CTRL: d.rdata = {30'h00000000, q.af};
          REG_DESC0: d.rdata = {q.own, 15'h0000, q.stat};
          REG_DESC1: d.rdata = q.w1;
          REG_DESC2: d.rdata = q.w2;
          REG_DESC3: d.rdata = q.w3;
          REG_STAT: begin
            d.rdata[ST_TI_BIT] = q.ti;
            d.rdata[ST_BUSY_BIT] = q.st != ST_IDLE;
            d.rdata[ST_HASH_BIT] = q.hash_mode;
            d.rdata[ST_INV_BIT] = q.inverse;
          end
          REG_FLEN: d.rdata = {16'h0000, q.flen};
          default: d.rdata = 32'h00000000;
        endcase
      end
    end

    // Software writes; descriptor words are locked while a hand-off runs
    if (wr_en_i) begin
      if (addr_i[BUF_SEL_BIT]) begin
        d.sbuf[addr_i[6:2]] = wr_data_i;
      end else begin
        unique case (addr_i)
          REG_CTRL: d.af = wr_data_i[1:0];
          REG_DESC1: if (q.st == ST_IDLE) d.w1 = wr_data_i;
          REG_DESC2: if (q.st == ST_IDLE) d.w2 = wr_data_i;
          REG_DESC3: if (q.st == ST_IDLE) d.w3 = wr_data_i;
          REG_DESC0: begin
            if (q.st == ST_IDLE && wr_data_i[OWN_BIT]) begin
              d.own = 1'b1;
              d.stat = 16'h0000;
              d.st = ST_DECODE;
            end
          end
          REG_STAT: if (wr_data_i[ST_TI_BIT]) d.ti = 1'b0;
          default: ;
        endcase
      end
    end

    // Descriptor processing
    unique case (q.st)
      ST_IDLE: ;
      ST_DECODE: begin
        if (q.w1[CA_BIT]) begin
          // Chain word points at the next descriptor; ownership kept
          d.chain = 1'b1;
          d.seg_addr = q.w3;
          d.done = 1'b1;
          d.st = ST_IDLE;
        end else if (txdaf_type(q.w1) == DT_SETUP) begin
          d.st = ST_SETUP_WAIT;
        end else begin
          // Start of frame resets the sum and samples the inhibit
          if (q.w1[FS_BIT]) begin
            nlen = {1'b0, bs};
            ninh = q.w1[AC_BIT];
          end else begin
            nlen = q.flen + {1'b0, bs};
            ninh = q.inh;
          end
          d.flen = nlen;
          d.inh = ninh;
          // A zero-size buffer is passed over with no fetch
          if (bs != 15'h0000) begin
            d.seg_req = 1'b1;
            d.seg_addr = q.w3;
            d.seg_pte = q.w1[VA_BIT];
            d.seg_kind = q.w1[VA_BIT] & q.w1[VT_BIT];
            // Offset only matters for a translated buffer
            d.seg_off = q.w1[VA_BIT] ? q.w2[PO_HI:0] : 9'h000;
            d.seg_len = bs;
            d.ctype = txdaf_type(q.w1);
          end
          if (q.w1[LS_BIT]) begin
            d.frame_end = 1'b1;
            d.frame_len = nlen;
            d.pad = nlen < MIN_FRAME;
            d.crc_app = !ninh || (nlen < MIN_FRAME);
            d.st = ST_TX_WAIT;
          end else begin
            d.own = 1'b0;
            d.done = 1'b1;
            d.st = ST_IDLE;
          end
        end
      end
      ST_TX_WAIT: begin
        if (tx_done_i) begin
          // Summary comes from the raw report and is always valid
          es = rep[UF_BIT] | rep[TN_BIT] | rep[EC_BIT] | rep[LC_BIT] |
            rep[NC_BIT] | rep[LO_BIT] | rep[LE_BIT] | rep[TO_BIT];
          if (rep[EC_BIT]) begin
            rep[CC_HI:CC_LO] = 4'h0;
          end
          if (rep[UF_BIT] || rep[TO_BIT] || loopback_i) begin
            rep[LO_BIT] = 1'b0;
            rep[HF_BIT] = 1'b0;
          end
          if (rep[UF_BIT] || loopback_i) begin
            rep[NC_BIT] = 1'b0;
          end
          rep[SE_BIT] = 1'b0;
          d.stat = {es, rep};
          d.own = 1'b0;
          d.done = 1'b1;
          if (q.w1[IC_BIT]) begin
            d.ti = 1'b1;
          end
          d.st = ST_IDLE;
        end
      end
      ST_SETUP_WAIT: begin
        // Earlier frames are already done since descriptors run in order
        if (tx_running_i && !rx_busy_i) begin
          d.disengage = 1'b1;
          d.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (bs == SETUP_LEN) begin
          // Whole table is replaced at once, never half-loaded
          d.ftab = q.sbuf;
          d.hash_mode = q.w1[HP_BIT];
          d.inverse = q.w1[IF_BIT];
        end else begin
          d.stat[SE_BIT] = 1'b1;
          d.stat[ES_BIT] = 1'b1;
        end
        d.own = 1'b0;
        d.done = 1'b1;
        d.disengage = 1'b0;
        if (q.w1[IC_BIT]) begin
          d.ti = 1'b1;
        end
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase

    // Address filter verdict, one cycle after the destination strobe
    if (q.af[AF_PROM_BIT]) begin
      acc = 1'b1;
    end else if (mcast && q.af[AF_MULTI_BIT]) begin
      acc = 1'b1;
    end else if (q.hash_mode) begin
      if (mcast) begin
        acc = hash_bits[hash_idx];
      end else begin
        acc = dest_addr_i == {q.ftab[HASH_PHYS_WORD+1][15:0],
          q.ftab[HASH_PHYS_WORD]};
      end
    end else begin
      // Cleared table holds zero entries, so only zero matches
      acc = (|pmatch) ^ q.inverse;
    end
    if (dest_valid_i) begin
      d.fvalid = 1'b1;
      d.faccept = acc;
    end
  end

  // Single state register; the table comes up all zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Every output is a flip-flop of the state record
  assign rd_data_o = q.rdata;
  assign seg_req_o = q.seg_req;
  assign seg_addr_o = q.seg_addr;
  assign seg_is_pte_o = q.seg_pte;
  assign seg_pte_kind_o = q.seg_kind;
  assign seg_offset_o = q.seg_off;
  assign seg_len_o = q.seg_len;
  assign content_type_o = q.ctype;
  assign frame_end_o = q.frame_end;
  assign frame_len_o = q.frame_len;
  assign crc_append_o = q.crc_app;
  assign pad_o = q.pad;
  assign chain_o = q.chain;
  assign desc_done_o = q.done;
  assign rx_disengage_o = q.disengage;
  assign tx_interrupt_flag_o = q.ti;
  assign filter_valid_o = q.fvalid;
  assign filter_accept_o = q.faccept;
endmodule
`default_nettype wire
